// >>> regfile_pkg.sv
// constants, field layouts and carrier types of the banked register file
package regfile_pkg;

  localparam int unsigned XLEN = 32;
  localparam int unsigned ADR_W = 12;

  // byte addresses on the register bus
  localparam logic [11:0] GEN_BASE = 12'h000;
  localparam logic [11:0] ALT_BASE = 12'h040;
  localparam logic [11:0] STATUS_ADR = 12'h080;
  localparam logic [11:0] GLOBAL_BASE_ADR = 12'h084;
  localparam logic [11:0] SAVED_STATUS_ADR = 12'h088;
  localparam logic [11:0] SAVED_PC_ADR = 12'h08c;
  localparam logic [11:0] VECTOR_BASE_ADR = 12'h090;
  localparam logic [11:0] SAVED_STACK_ADR = 12'h094;
  localparam logic [11:0] DEBUG_BASE_ADR = 12'h098;
  localparam logic [11:0] MAC_HIGH_ADR = 12'h0a0;
  localparam logic [11:0] MAC_LOW_ADR = 12'h0a4;
  localparam logic [11:0] PROC_RET_ADR = 12'h0a8;
  localparam logic [11:0] PC_ADR = 12'h0ac;
  localparam logic [11:0] FP_STATUS_ADR = 12'h0b0;
  localparam logic [11:0] FP_COMM_ADR = 12'h0b4;
  localparam logic [11:0] FP_FRONT_BASE = 12'h100;
  localparam logic [11:0] FP_BACK_BASE = 12'h140;

  // status word fields
  localparam int unsigned PRIV_BIT = 30;
  localparam int unsigned BANK_BIT = 29;
  localparam int unsigned BLOCK_BIT = 28;
  localparam int unsigned FPU_DIS_BIT = 15;
  localparam int unsigned IMASK_LSB = 4;
  localparam logic [31:0] STATUS_RST = 32'h700000f0;
  localparam logic [31:0] STATUS_PRIV_MASK = 32'h700080f0;
  localparam logic [31:0] STATUS_USER_MASK = 32'h00000303;

  // fp status bit that swaps which physical bank is the front set
  localparam int unsigned FP_BANK_BIT = 21;

  localparam logic [31:0] VECTOR_BASE_RST = 32'h00000000;
  localparam logic [31:0] PC_RST = 32'h0a000000;
  localparam logic [31:0] FP_STATUS_RST = 32'h00040001;
  localparam logic [31:0] ZERO_RST = 32'h00000000;

  typedef struct packed {
    logic sign;
    logic [7:0] exp;
    logic [22:0] frac;
  } sp_float_s;

  typedef struct packed {
    logic sign;
    logic [10:0] exp;
    logic [51:0] frac;
  } dp_float_s;

  typedef struct packed {
    logic priv_mode;
    logic bank_sel;
    logic block;
    logic fpu_disable;
    logic [3:0] imask;
  } mode_view_s;

endpackage : regfile_pkg

// >>> banked_cpu_register_file.sv
// banked general, control, system and floating-point registers of the core
//
// Operation
// - user mode normally; exception or accepted interrupt enters privileged mode.
// - sixteen general registers; indices 0-7 in two banks, 8-15 shared.
// - privileged with bank select 1: indices 0-7 are bank 1, bank 0 via alternate view.
// - privileged with bank select 0: indices 0-7 are bank 0, bank 1 via alternate view.
// - user mode always uses bank 0; bank 1 unreachable.
// - global base and status open to both modes; saved and base registers privileged only.
// - privileged status bits, bank select among them, accessible only in privileged mode.
// - mac, procedure return, pc, fp status and fp communication open in both modes.
// - thirty-two fp registers: front and back sets over two physical banks.
// - front set as pairs or vectors, back set as pairs or a matrix.
// - single precision: sign bit 31, exponent 30-23, fraction 22-0.
// - double precision: sign bit 63, exponent 62-52, fraction 51-0.
// - status resets to privileged, bank 1, blocked, fpu enabled, mask all ones.
// - reset values load on power-on and manual reset alike.
// - user or privileged mode follows only the status privilege bit.
//
// The Wishbone slave port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
module banked_cpu_register_file (
  input wire logic clk_sys_i, // core clock, 25 MHz
  input wire logic rst_b_i, // synchronous reset, power-on or manual
  input wire logic cyc_i, // wishbone cycle
  input wire logic stb_i, // wishbone strobe
  input wire logic we_i, // wishbone write enable
  input wire logic [11:0] adr_i, // wishbone byte address
  input wire logic [3:0] sel_i, // wishbone byte enables
  input wire logic [31:0] dat_i, // wishbone write data
  output logic [31:0] dat_o, // wishbone read data
  output logic ack_o, // wishbone acknowledge
  input wire logic exc_take_i, // exception or interrupt accepted, pulse
  input wire logic [31:0] exc_pc_i, // pc to save on exception entry
  input wire logic exc_return_i, // return from exception, pulse
  input wire logic [3:0] fp_single_idx_i, // front single index
  input wire logic [2:0] fp_pair_idx_i, // pair index, even register = idx*2
  input wire logic [1:0] fp_vector_idx_i, // vector index, base = idx*4
  output regfile_pkg::sp_float_s fp_single_o, // front single view
  output regfile_pkg::dp_float_s fp_pair_o, // front double pair view
  output regfile_pkg::dp_float_s fp_back_pair_o, // back pair view
  output logic [127:0] fp_vector_o, // front vector, element 0 in low word
  output logic [511:0] fp_matrix_o, // back matrix, element 0 in low word
  output regfile_pkg::mode_view_s mode_o, // current status fields
  output logic priv_fault_o // user access blocked, one-cycle pulse
);

  logic [31:0] bank0_general [0:7];
  logic [31:0] bank1_general [0:7];
  logic [31:0] shared_general [0:7];
  logic [31:0] fp_bank0 [0:15];
  logic [31:0] fp_bank1 [0:15];
  logic [31:0] status_word_r, global_base_r, saved_status_r, saved_program_counter_r;
  logic [31:0] vector_base_r, saved_stack_general_r, debug_base_r;
  logic [31:0] mac_high_r, mac_low_r, procedure_return_r, pc_r, fp_status_control_r, fp_communication_r;
  logic ack_r, fault_r;
  logic [31:0] dat_r, rd_val;

  wire logic req = cyc_i & stb_i;
  wire logic req_go = req & ~ack_r;
  wire logic wr_go = req & ack_r & we_i;
  wire logic privilege_bit = status_word_r[regfile_pkg::PRIV_BIT];
  wire logic bank_select_bit = status_word_r[regfile_pkg::BANK_BIT];
  wire logic use_bank1 = privilege_bit & bank_select_bit;
  wire logic fp_swap = fp_status_control_r[regfile_pkg::FP_BANK_BIT];
  wire logic is_gen = adr_i[11:6] == regfile_pkg::GEN_BASE[11:6];
  wire logic is_alt = adr_i[11:5] == regfile_pkg::ALT_BASE[11:5];
  wire logic is_fpf = adr_i[11:6] == regfile_pkg::FP_FRONT_BASE[11:6];
  wire logic is_fpb = adr_i[11:6] == regfile_pkg::FP_BACK_BASE[11:6];
  wire logic [3:0] gidx = adr_i[5:2];
  wire logic [2:0] lidx = adr_i[4:2];
  wire logic is_status = adr_i == regfile_pkg::STATUS_ADR;
  wire logic priv_only = is_alt | adr_i == regfile_pkg::SAVED_STATUS_ADR
    | adr_i == regfile_pkg::SAVED_PC_ADR | adr_i == regfile_pkg::VECTOR_BASE_ADR
    | adr_i == regfile_pkg::SAVED_STACK_ADR | adr_i == regfile_pkg::DEBUG_BASE_ADR;
  wire logic [31:0] wmask = {{8{sel_i[3]}}, {8{sel_i[2]}}, {8{sel_i[1]}}, {8{sel_i[0]}}};
  wire logic status_touch = is_status & we_i
    & |((dat_i ^ status_word_r) & wmask & regfile_pkg::STATUS_PRIV_MASK);
  wire logic fault = ~privilege_bit & (priv_only | status_touch);
  wire logic wr_ok = wr_go & ~fault;
  wire logic [31:0] status_wmask = wmask & (privilege_bit ?
    (regfile_pkg::STATUS_PRIV_MASK | regfile_pkg::STATUS_USER_MASK) : regfile_pkg::STATUS_USER_MASK);

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  // front set reads the bank picked by fp_swap, back set the other one
  function automatic logic [31:0] fp_rd(input logic back, input logic [3:0] i);
    fp_rd = (back ^ fp_swap) ? fp_bank1[i] : fp_bank0[i];
  endfunction : fp_rd

  always_comb begin
    rd_val = 32'h00000000;
    if (is_gen) begin
      if (gidx[3]) rd_val = shared_general[gidx[2:0]];
      else rd_val = use_bank1 ? bank1_general[gidx[2:0]] : bank0_general[gidx[2:0]];
    end else if (is_alt) begin
      rd_val = bank_select_bit ? bank0_general[lidx] : bank1_general[lidx];
    end else if (is_fpf) begin
      rd_val = fp_rd(1'b0, gidx);
    end else if (is_fpb) begin
      rd_val = fp_rd(1'b1, gidx);
    end else begin
      case (adr_i)
        regfile_pkg::STATUS_ADR: rd_val = status_word_r & (privilege_bit ? 32'hffffffff :
          regfile_pkg::STATUS_USER_MASK);
        regfile_pkg::GLOBAL_BASE_ADR: rd_val = global_base_r;
        regfile_pkg::SAVED_STATUS_ADR: rd_val = saved_status_r;
        regfile_pkg::SAVED_PC_ADR: rd_val = saved_program_counter_r;
        regfile_pkg::VECTOR_BASE_ADR: rd_val = vector_base_r;
        regfile_pkg::SAVED_STACK_ADR: rd_val = saved_stack_general_r;
        regfile_pkg::DEBUG_BASE_ADR: rd_val = debug_base_r;
        regfile_pkg::MAC_HIGH_ADR: rd_val = mac_high_r;
        regfile_pkg::MAC_LOW_ADR: rd_val = mac_low_r;
        regfile_pkg::PROC_RET_ADR: rd_val = procedure_return_r;
        regfile_pkg::PC_ADR: rd_val = pc_r;
        regfile_pkg::FP_STATUS_ADR: rd_val = fp_status_control_r;
        regfile_pkg::FP_COMM_ADR: rd_val = fp_communication_r;
        default: rd_val = 32'h00000000;
      endcase
    end
  end

  // bus slave: ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      ack_r <= 1'b0;
      dat_r <= 32'h00000000;
      fault_r <= 1'b0;
    end else begin
      ack_r <= req_go;
      fault_r <= req_go & fault;
      if (req_go) dat_r <= fault ? 32'h00000000 : rd_val;
    end
  end

  // control and system registers with defined reset values
  always_ff @(posedge clk_sys_i) begin
    if (!rst_b_i) begin
      status_word_r <= regfile_pkg::STATUS_RST;
      vector_base_r <= regfile_pkg::VECTOR_BASE_RST;
      pc_r <= regfile_pkg::PC_RST;
      fp_status_control_r <= regfile_pkg::FP_STATUS_RST;
      global_base_r <= regfile_pkg::ZERO_RST;
      saved_status_r <= regfile_pkg::ZERO_RST;
      saved_program_counter_r <= regfile_pkg::ZERO_RST;
      saved_stack_general_r <= regfile_pkg::ZERO_RST;
      debug_base_r <= regfile_pkg::ZERO_RST;
      mac_high_r <= regfile_pkg::ZERO_RST;
      mac_low_r <= regfile_pkg::ZERO_RST;
      procedure_return_r <= regfile_pkg::ZERO_RST;
      fp_communication_r <= regfile_pkg::ZERO_RST;
    end else if (exc_take_i) begin
      saved_status_r <= status_word_r;
      saved_program_counter_r <= exc_pc_i;
      saved_stack_general_r <= shared_general[7];
      status_word_r <= status_word_r | (32'h00000001 << regfile_pkg::PRIV_BIT)
        | (32'h00000001 << regfile_pkg::BANK_BIT) | (32'h00000001 << regfile_pkg::BLOCK_BIT);
    end else if (exc_return_i) begin
      status_word_r <= saved_status_r;
      pc_r <= saved_program_counter_r;
    end else if (wr_ok) begin
      case (adr_i)
        regfile_pkg::STATUS_ADR: status_word_r <= merge(status_word_r, dat_i, status_wmask);
        regfile_pkg::GLOBAL_BASE_ADR: global_base_r <= merge(global_base_r, dat_i, wmask);
        regfile_pkg::SAVED_STATUS_ADR: saved_status_r <= merge(saved_status_r, dat_i, wmask);
        regfile_pkg::SAVED_PC_ADR: saved_program_counter_r <= merge(saved_program_counter_r, dat_i, wmask);
        regfile_pkg::VECTOR_BASE_ADR: vector_base_r <= merge(vector_base_r, dat_i, wmask);
        regfile_pkg::SAVED_STACK_ADR: saved_stack_general_r <= merge(saved_stack_general_r, dat_i, wmask);
        regfile_pkg::DEBUG_BASE_ADR: debug_base_r <= merge(debug_base_r, dat_i, wmask);
        regfile_pkg::MAC_HIGH_ADR: mac_high_r <= merge(mac_high_r, dat_i, wmask);
        regfile_pkg::MAC_LOW_ADR: mac_low_r <= merge(mac_low_r, dat_i, wmask);
        regfile_pkg::PROC_RET_ADR: procedure_return_r <= merge(procedure_return_r, dat_i, wmask);
        regfile_pkg::PC_ADR: pc_r <= merge(pc_r, dat_i, wmask);
        regfile_pkg::FP_STATUS_ADR: fp_status_control_r <= merge(fp_status_control_r, dat_i, wmask);
        regfile_pkg::FP_COMM_ADR: fp_communication_r <= merge(fp_communication_r, dat_i, wmask);
        default: ;
      endcase
    end
  end

  // data registers keep no reset value; one index of each fp bank per generate slot, of each general bank in slots 0-7 only
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_entry
      if (gi < 8) begin : g_gen
        wire logic hit_cur = wr_ok & is_gen & gidx == 4'(gi);
        wire logic hit_alt = wr_ok & is_alt & lidx == 3'(gi);
        always_ff @(posedge clk_sys_i) begin
          if ((hit_cur & ~use_bank1) | (hit_alt & bank_select_bit)) begin
            bank0_general[gi] <= merge(bank0_general[gi], dat_i, wmask);
          end
          if ((hit_cur & use_bank1) | (hit_alt & ~bank_select_bit)) begin
            bank1_general[gi] <= merge(bank1_general[gi], dat_i, wmask);
          end
          if (wr_ok & is_gen & gidx == 4'(gi + 8)) begin
            shared_general[gi] <= merge(shared_general[gi], dat_i, wmask);
          end
        end
      end
      wire logic fp_hit = wr_ok & (is_fpf | is_fpb) & gidx == 4'(gi);
      wire logic fp_to1 = is_fpb ^ fp_swap;
      always_ff @(posedge clk_sys_i) begin
        if (fp_hit & ~fp_to1) fp_bank0[gi] <= merge(fp_bank0[gi], dat_i, wmask);
        if (fp_hit & fp_to1) fp_bank1[gi] <= merge(fp_bank1[gi], dat_i, wmask);
      end
    end
  endgenerate

  // registered fp views for the pipeline
  wire logic [3:0] pair_even = {fp_pair_idx_i, 1'b0};
  wire logic [3:0] pair_odd = {fp_pair_idx_i, 1'b1};
  wire logic [3:0] vec_base = {fp_vector_idx_i, 2'b00};
  always_ff @(posedge clk_sys_i) begin
    fp_single_o <= regfile_pkg::sp_float_s'(fp_rd(1'b0, fp_single_idx_i));
    fp_pair_o <= regfile_pkg::dp_float_s'({fp_rd(1'b0, pair_even), fp_rd(1'b0, pair_odd)});
    fp_back_pair_o <= regfile_pkg::dp_float_s'({fp_rd(1'b1, pair_even), fp_rd(1'b1, pair_odd)});
    fp_vector_o <= {fp_rd(1'b0, vec_base | 4'h3), fp_rd(1'b0, vec_base | 4'h2),
      fp_rd(1'b0, vec_base | 4'h1), fp_rd(1'b0, vec_base)};
    for (int k = 0; k < 16; k++) begin
      fp_matrix_o[k*32 +: 32] <= fp_rd(1'b1, 4'(k));
    end
  end

  assign dat_o = dat_r;
  assign ack_o = ack_r;
  assign priv_fault_o = fault_r;
  assign mode_o = '{privilege_bit, bank_select_bit, status_word_r[regfile_pkg::BLOCK_BIT],
    status_word_r[regfile_pkg::FPU_DIS_BIT], status_word_r[regfile_pkg::IMASK_LSB +: 4]};

  property p_exc_priv;
    @(posedge clk_sys_i) disable iff (!rst_b_i) exc_take_i |=> mode_o.priv_mode && mode_o.bank_sel && mode_o.block;
  endproperty
  a_exc_priv: assert property (p_exc_priv) else $error("exception did not enter privileged mode");

  property p_reset_status;
    @(posedge clk_sys_i) !rst_b_i |=> status_word_r == regfile_pkg::STATUS_RST && pc_r == regfile_pkg::PC_RST
      && fp_status_control_r == regfile_pkg::FP_STATUS_RST && vector_base_r == regfile_pkg::VECTOR_BASE_RST;
  endproperty
  a_reset_status: assert property (p_reset_status) else $error("reset values not loaded");

  property p_user_fault;
    @(posedge clk_sys_i) disable iff (!rst_b_i) req_go && !privilege_bit && priv_only
      |=> ack_o && priv_fault_o && dat_o == 32'h00000000 ##1 !ack_o;
  endproperty
  a_user_fault: assert property (p_user_fault) else $error("user access to privileged register not blocked");

  property p_user_status;
    @(posedge clk_sys_i) disable iff (!rst_b_i) wr_go && !privilege_bit && !exc_take_i && !exc_return_i
      |=> (status_word_r & regfile_pkg::STATUS_PRIV_MASK) == ($past(status_word_r) & regfile_pkg::STATUS_PRIV_MASK);
  endproperty
  a_user_status: assert property (p_user_status) else $error("user write changed privileged status bits");

  property p_user_bank0;
    @(posedge clk_sys_i) disable iff (!rst_b_i) wr_go && is_gen && !gidx[3] && !privilege_bit && sel_i == 4'hf
      |=> bank0_general[$past(gidx[2:0])] == $past(dat_i);
  endproperty
  a_user_bank0: assert property (p_user_bank0) else $error("user mode write missed bank 0");

  property p_priv_bank1;
    @(posedge clk_sys_i) disable iff (!rst_b_i) wr_go && is_gen && !gidx[3] && use_bank1 && sel_i == 4'hf
      |=> bank1_general[$past(gidx[2:0])] == $past(dat_i);
  endproperty
  a_priv_bank1: assert property (p_priv_bank1) else $error("bank 1 write missed");

  property p_alt_bank1;
    @(posedge clk_sys_i) disable iff (!rst_b_i) wr_go && is_alt && privilege_bit && !bank_select_bit && sel_i == 4'hf
      |=> bank1_general[$past(lidx)] == $past(dat_i);
  endproperty
  a_alt_bank1: assert property (p_alt_bank1) else $error("alternate view did not reach bank 1");

  property p_sys_open;
    @(posedge clk_sys_i) disable iff (!rst_b_i) req_go && adr_i == regfile_pkg::MAC_HIGH_ADR |=> ack_o && !priv_fault_o;
  endproperty
  a_sys_open: assert property (p_sys_open) else $error("system register access faulted");

  property p_pair_view;
    @(posedge clk_sys_i) disable iff (!rst_b_i) wr_go && is_fpf && sel_i == 4'hf
      && gidx == {fp_pair_idx_i, 1'b0} ##1 !wr_go && $stable(fp_pair_idx_i)
      |=> fp_pair_o[63:32] == $past(dat_i, 2) && fp_pair_o.sign == $past(dat_i[31], 2);
  endproperty
  a_pair_view: assert property (p_pair_view) else $error("double pair view wrong");

  // view, bank, access and mode checks against written, reset and saved values
  property p_single_view;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      wr_go && is_fpf && sel_i == 4'hf && gidx == fp_single_idx_i
      ##1 !wr_go && $stable(fp_single_idx_i)
      |=> fp_single_o.sign == $past(dat_i[31], 2) && fp_single_o.exp == $past(dat_i[30:23], 2);
  endproperty
  a_single_view: assert property (p_single_view) else $error("single view fields wrong");

  property p_shared_wr;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      wr_go && is_gen && gidx[3] && sel_i == 4'hf
      |=> shared_general[$past(gidx[2:0])] == $past(dat_i);
  endproperty
  a_shared_wr: assert property (p_shared_wr) else $error("shared general write missed");

  property p_back_wr;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      wr_go && is_fpb && sel_i == 4'hf
      |=> ($past(fp_swap) ? fp_bank0[$past(gidx)] : fp_bank1[$past(gidx)]) == $past(dat_i);
  endproperty
  a_back_wr: assert property (p_back_wr) else $error("back set write reached wrong bank");

  property p_open_ctrl;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      req_go && (adr_i == regfile_pkg::GLOBAL_BASE_ADR || (adr_i == regfile_pkg::STATUS_ADR && !we_i))
      |=> ack_o && !priv_fault_o;
  endproperty
  a_open_ctrl: assert property (p_open_ctrl) else $error("open control register faulted");

  property p_mode_reset;
    @(posedge clk_sys_i)
      !rst_b_i
      |=> mode_o.priv_mode && mode_o.bank_sel && mode_o.block && !mode_o.fpu_disable && mode_o.imask == 4'hf;
  endproperty
  a_mode_reset: assert property (p_mode_reset) else $error("mode fields wrong after reset");

  property p_priv_follow;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      wr_ok && is_status && privilege_bit && sel_i[3] && !exc_take_i && !exc_return_i
      |=> mode_o.priv_mode == $past(dat_i[regfile_pkg::PRIV_BIT]);
  endproperty
  a_priv_follow: assert property (p_priv_follow) else $error("mode did not follow privilege bit");

  property p_exc_save;
    @(posedge clk_sys_i) disable iff (!rst_b_i)
      exc_take_i
      |=> saved_program_counter_r == $past(exc_pc_i) && saved_status_r == $past(status_word_r);
  endproperty
  a_exc_save: assert property (p_exc_save) else $error("exception entry state not saved");

  // main scenarios reached by the bench
  c_fault: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i) priv_fault_o);
  c_exc: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i) exc_take_i ##[1:20] exc_return_i);
  c_alt_wr: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i) wr_ok && is_alt);
  c_user_gen: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i) wr_ok && is_gen && !privilege_bit);
  c_fp_swap: cover property (@(posedge clk_sys_i) disable iff (!rst_b_i) $rose(fp_swap));

endmodule : banked_cpu_register_file

// >>> pipeline_model.sv
// behavioural pipeline partner: exception pulses and fp view selection
`timescale 1ns/10ps
module pipeline_model (
  input wire logic clk_sys_i, // core clock
  output logic exc_take_o, // exception accepted pulse
  output logic [31:0] exc_pc_o, // pc saved on entry
  output logic exc_return_o, // exception return pulse
  output logic [3:0] single_idx_o, // front single index
  output logic [2:0] pair_idx_o, // pair index
  output logic [1:0] vector_idx_o // vector index
);
  initial begin
    exc_take_o = 1'b0;
    exc_pc_o = 32'h0;
    exc_return_o = 1'b0;
    single_idx_o = 4'h0;
    pair_idx_o = 3'h0;
    vector_idx_o = 2'h0;
  end

  // gap sets how slowly the pipeline reacts before the pulse
  task automatic take_exc(input logic [31:0] pc, input int gap);
    repeat (gap) @(posedge clk_sys_i);
    exc_take_o <= 1'b1;
    exc_pc_o <= pc;
    @(posedge clk_sys_i);
    exc_take_o <= 1'b0;
    exc_pc_o <= ~pc; // pc is not held past the pulse
  endtask : take_exc

  task automatic ret_exc(input int gap);
    repeat (gap) @(posedge clk_sys_i);
    exc_return_o <= 1'b1;
    @(posedge clk_sys_i);
    exc_return_o <= 1'b0;
  endtask : ret_exc

  task automatic set_view(input logic [3:0] s, input logic [2:0] p, input logic [1:0] v);
    @(posedge clk_sys_i);
    single_idx_o <= s;
    pair_idx_o <= p;
    vector_idx_o <= v;
  endtask : set_view
endmodule : pipeline_model

// >>> banked_cpu_register_file_bench.sv
// self-checking bench of the banked register file
`timescale 1ns/10ps
module banked_cpu_register_file_bench;
  logic clk_sys_i, rst_b_i, cyc_i, stb_i, we_i;
  logic [11:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o;
  logic ack_o, priv_fault_o, exc_take, exc_return;
  logic [31:0] exc_pc;
  logic [3:0] s_idx;
  logic [2:0] p_idx;
  logic [1:0] v_idx;
  regfile_pkg::sp_float_s fp_single_o;
  regfile_pkg::dp_float_s fp_pair_o, fp_back_pair_o;
  logic [127:0] fp_vector_o;
  logic [511:0] fp_matrix_o;
  regfile_pkg::mode_view_s mode_o;
  int err_total = 0;
  int n_tests = 0;

  banked_cpu_register_file DUT (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .exc_take_i(exc_take), .exc_pc_i(exc_pc), .exc_return_i(exc_return), .fp_single_idx_i(s_idx),
    .fp_pair_idx_i(p_idx), .fp_vector_idx_i(v_idx), .fp_single_o(fp_single_o), .fp_pair_o(fp_pair_o),
    .fp_back_pair_o(fp_back_pair_o), .fp_vector_o(fp_vector_o), .fp_matrix_o(fp_matrix_o),
    .mode_o(mode_o), .priv_fault_o(priv_fault_o));

  pipeline_model u_pipe (.clk_sys_i(clk_sys_i), .exc_take_o(exc_take), .exc_pc_o(exc_pc),
    .exc_return_o(exc_return), .single_idx_o(s_idx), .pair_idx_o(p_idx), .vector_idx_o(v_idx));

  always #20 clk_sys_i = ~clk_sys_i;

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // classic cycle: held until ack is sampled, released at that edge
  task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                    output logic f);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    q = dat_o;
    f = priv_fault_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    dat_i <= ~d;
    chk("ack", 64'h1, {63'h0, ack_o});
  endtask : wb

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic fe);
    logic [31:0] q;
    logic f;
    wb(1'b1, a, d, q, f);
    chk("write fault", {63'h0, fe}, {63'h0, f});
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic fe);
    logic [31:0] q;
    logic f;
    wb(1'b0, a, 32'h0, q, f);
    chk("read data", {32'h0, e}, {32'h0, q});
    chk("read fault", {63'h0, fe}, {63'h0, f});
  endtask : rd

  task automatic t_reset;
    rd(regfile_pkg::STATUS_ADR, 32'h700000f0, 1'b0);
    chk("mode", 64'hef, {56'h0, mode_o});
    rd(regfile_pkg::PC_ADR, 32'h0a000000, 1'b0);
    rd(regfile_pkg::VECTOR_BASE_ADR, 32'h0, 1'b0);
    rd(regfile_pkg::FP_STATUS_ADR, 32'h00040001, 1'b0);
    $display("test reset values done");
  endtask : t_reset

  task automatic t_bank;
    wr(regfile_pkg::GEN_BASE, 32'h11111111, 1'b0);
    wr(regfile_pkg::ALT_BASE, 32'h22222222, 1'b0);
    wr(regfile_pkg::GEN_BASE + 12'h03c, 32'h33333333, 1'b0);
    wr(regfile_pkg::STATUS_ADR, 32'h500000f0, 1'b0);
    @(posedge clk_sys_i);
    chk("bank sel", 64'h0, {63'h0, mode_o.bank_sel});
    rd(regfile_pkg::GEN_BASE, 32'h22222222, 1'b0);
    rd(regfile_pkg::ALT_BASE, 32'h11111111, 1'b0);
    wr(regfile_pkg::ALT_BASE + 12'h004, 32'h88888888, 1'b0);
    wr(regfile_pkg::STATUS_ADR, 32'h700000f0, 1'b0);
    rd(regfile_pkg::GEN_BASE, 32'h11111111, 1'b0);
    rd(regfile_pkg::ALT_BASE, 32'h22222222, 1'b0);
    rd(regfile_pkg::GEN_BASE + 12'h004, 32'h88888888, 1'b0);
    rd(regfile_pkg::GEN_BASE + 12'h03c, 32'h33333333, 1'b0);
    $display("test banking done");
  endtask : t_bank

  task automatic t_fp;
    u_pipe.set_view(4'h2, 3'h1, 2'h0);
    wr(regfile_pkg::FP_FRONT_BASE + 12'h008, 32'hc0490fdb, 1'b0);
    wr(regfile_pkg::FP_FRONT_BASE + 12'h00c, 32'h12345678, 1'b0);
    wr(regfile_pkg::FP_BACK_BASE + 12'h008, 32'h3f800000, 1'b0);
    wr(regfile_pkg::FP_BACK_BASE + 12'h00c, 32'h9abcdef0, 1'b0);
    repeat (3) @(posedge clk_sys_i);
    chk("sp sign", 64'h1, {63'h0, fp_single_o.sign});
    chk("sp exp", 64'h80, {56'h0, fp_single_o.exp});
    chk("sp frac", 64'h490fdb, {41'h0, fp_single_o.frac});
    chk("pair", 64'hc0490fdb12345678, fp_pair_o);
    chk("dp exp", 64'h404, {53'h0, fp_pair_o.exp});
    chk("back pair", 64'h3f8000009abcdef0, fp_back_pair_o);
    chk("vector", 64'h12345678c0490fdb, fp_vector_o[127:64]);
    chk("matrix", 64'h9abcdef03f800000, fp_matrix_o[127:64]);
    wr(regfile_pkg::FP_STATUS_ADR, 32'h00240001, 1'b0);
    repeat (3) @(posedge clk_sys_i);
    chk("swapped single", 64'h3f800000, {32'h0, fp_single_o});
    rd(regfile_pkg::FP_BACK_BASE + 12'h008, 32'hc0490fdb, 1'b0);
    $display("test fp views done");
  endtask : t_fp

  task automatic t_user;
    wr(regfile_pkg::STATUS_ADR, 32'h000000f0, 1'b0);
    @(posedge clk_sys_i);
    chk("priv", 64'h0, {63'h0, mode_o.priv_mode});
    rd(regfile_pkg::GEN_BASE, 32'h22222222, 1'b0);
    wr(regfile_pkg::GEN_BASE + 12'h004, 32'h77777777, 1'b0);
    rd(regfile_pkg::GEN_BASE + 12'h004, 32'h77777777, 1'b0);
    rd(regfile_pkg::ALT_BASE, 32'h0, 1'b1);
    wr(regfile_pkg::ALT_BASE, 32'h44444444, 1'b1);
    rd(regfile_pkg::SAVED_STATUS_ADR, 32'h0, 1'b1);
    wr(regfile_pkg::GLOBAL_BASE_ADR, 32'h55555555, 1'b0);
    rd(regfile_pkg::GLOBAL_BASE_ADR, 32'h55555555, 1'b0);
    wr(regfile_pkg::MAC_HIGH_ADR, 32'h66666666, 1'b0);
    rd(regfile_pkg::MAC_HIGH_ADR, 32'h66666666, 1'b0);
    wr(regfile_pkg::STATUS_ADR, 32'h20000000, 1'b1);
    rd(regfile_pkg::STATUS_ADR, 32'h0, 1'b0);
    u_pipe.take_exc(32'h0c001234, 3);
    repeat (2) @(posedge clk_sys_i);
    chk("priv after exc", 64'h1, {63'h0, mode_o.priv_mode});
    rd(regfile_pkg::GEN_BASE, 32'h11111111, 1'b0);
    rd(regfile_pkg::SAVED_PC_ADR, 32'h0c001234, 1'b0);
    rd(regfile_pkg::SAVED_STATUS_ADR, 32'h000000f0, 1'b0);
    u_pipe.ret_exc(0);
    repeat (2) @(posedge clk_sys_i);
    chk("priv after return", 64'h0, {63'h0, mode_o.priv_mode});
    $display("test user mode done");
  endtask : t_user

  task automatic t_rerst;
    @(posedge clk_sys_i);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    rd(regfile_pkg::STATUS_ADR, 32'h700000f0, 1'b0);
    rd(regfile_pkg::FP_STATUS_ADR, 32'h00040001, 1'b0);
    $display("test manual reset done");
  endtask : t_rerst

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    err_total++;
    finish_test();
  end

  initial begin
    clk_sys_i = 1'b0;
    rst_b_i = 1'b0;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 12'h0;
    sel_i = 4'hf;
    dat_i = 32'h0;
    repeat (16) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    t_reset();
    t_bank();
    t_fp();
    t_user();
    t_rerst();
    finish_test();
  end
endmodule : banked_cpu_register_file_bench
